/* File: hw/bcm_baud_detect.sv */
/*
 * serial line front end for in-system programming: times the start bit
 * of the first character, converts it to a timer reload value, and echoes
 * the receive line back out.
 * assumes rxd is synchronous to pclk and idles high.
 */
`timescale 1ns/1ps
`default_nettype none

module bcm_baud_detect import bcm_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic rxd,
    output logic txd,
    output logic locked,
    output logic [15:0] reload
);

    bcm_bd_state_type state, next_state;
    logic [BAUD_CNT_W-1:0] cnt, next_cnt;
    logic [15:0] next_reload;
    logic next_txd;
    logic [BAUD_CNT_W-BAUD_TICK_SHIFT-1:0] cnt_ticks;

    assign cnt_ticks = cnt[BAUD_CNT_W-1:BAUD_TICK_SHIFT];

    // ************************************************************
    // measurement state machine
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_reload = reload;
        next_txd = enable ? rxd : 1'b1;
        if (!enable) begin
            next_state = BD_WAIT_IDLE;
        end else begin
            case (state)
                BD_WAIT_IDLE: begin
                    if (rxd) begin
                        next_state = BD_WAIT_START;
                    end
                end
                BD_WAIT_START: begin
                    next_cnt = '0;
                    if (!rxd) begin
                        // the edge that first sees the line low already counts as a low cycle
                        next_cnt = BAUD_CNT_W'(1);
                        next_state = BD_MEASURE;
                    end
                end
                BD_MEASURE: begin
                    // start bit timing
                    // the first character is a U, so bit 0 high ends the start bit
                    if (rxd) begin
                        next_reload = 16'h0000 - cnt_ticks;
                        next_state = BD_LOCKED;
                    end else if (cnt != '1) begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                BD_LOCKED: begin
                    next_state = BD_LOCKED;
                end
                default: begin
                    next_state = BD_WAIT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= BD_WAIT_IDLE;
            cnt <= '0;
            reload <= 16'h0000;
            txd <= 1'b1;
            locked <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            reload <= next_reload;
            txd <= next_txd;
            locked <= (next_state == BD_LOCKED);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_echo;
        enable |=> txd == $past(rxd);
    endproperty
    a_echo: assert property (p_echo) else $error("received line not echoed");

    property p_lock;
        (state == BD_MEASURE && rxd && enable) |=> locked && reload == 16'(16'h0000 - $past(cnt_ticks));
    endproperty
    a_lock: assert property (p_lock) else $error("baud reload not taken from start bit");

    c_lock: cover property (enable ##[1:1000] locked);

endmodule : bcm_baud_detect

`default_nettype wire

/* File: hw/bcm_boot_clock_select.sv */
/*
 * boot and clock mode select: at reset release picks user code or the boot
 * loader, resolves the core clock divider, sequences flash byte and erase
 * operations, and hosts serial baud detection, all behind an apb slave.
 * assumes the flash array applies the operations it is handed, keeps the
 * status byte and speed fuse, and that pins are synchronous to pclk.
 */
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - 64K flash in sixteen erasable 4K blocks
// - flash read and written one byte
// - core runs at osc/12 or osc/6
// - programmed speed fuse forces six-clock
// - erased fuse: doubler bit picks mode
// - chip erase leaves fuse erased, twelve-clock
// - zero status byte: start user code
// - nonzero status byte: start boot loader
// - status byte ships as all ones
// - only chip erase restores all ones
// - strap pins also force boot loader
// - boot routines live in 1K boot memory
// - byte 8us, block 3s, chip 15s
// - external access low fetches externally
// - programming runs over the serial port
// - baud from one bit's measured time
// - every received character is echoed; the code echoes only while the boot loader runs and holds txd high otherwise
module bcm_boot_clock_select import bcm_pkg::*; #(
    parameter int unsigned BLK_ERASE_WAIT = BLK_ERASE_CYCLES,
    parameter int unsigned CHIP_ERASE_WAIT = CHIP_ERASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic program_store_strobe_n,
    input wire logic external_access_select_n,
    input wire logic address_latch_strobe,
    input wire logic [7:0] nv_status_byte,
    input wire logic nv_speed_fuse,
    input wire logic [7:0] flash_rdata,
    output bcm_op_type flash_op,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    input wire logic rxd,
    output logic txd,
    output logic config_valid,
    output logic run_boot,
    output logic [15:0] start_addr,
    output logic six_clk_mode,
    output logic core_clk_en,
    output logic ext_fetch
);

    logic next_config_valid, next_run_boot, next_six, next_ext_fetch, fuse_q, next_fuse;
    logic [15:0] next_start_addr;
    logic [7:0] status_q, next_status;
    logic strap_boot;
    logic [3:0] div_cnt, next_div_cnt, div_last;
    logic next_core_clk_en;
    bcm_fl_state_type fl_state, next_fl_state;
    bcm_op_type op_q, next_op, next_flash_op;
    logic [WAIT_W-1:0] wait_cnt, next_wait_cnt;
    logic ctrl_x2, next_x2;
    logic [15:0] addr_q, next_addr, next_flash_addr;
    logic [7:0] data_q, next_data, next_flash_wdata;
    logic wr_en;
    logic [2:0] cmd_code;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic baud_locked;
    logic [15:0] baud_reload;

    // ************************************************************
    // reset time configuration
    // ************************************************************
    assign strap_boot = !program_store_strobe_n && external_access_select_n && address_latch_strobe;

    always_comb begin
        next_config_valid = 1'b1;
        next_run_boot = run_boot;
        next_start_addr = start_addr;
        next_fuse = fuse_q;
        next_status = status_q;
        if (!config_valid) begin
            next_fuse = nv_speed_fuse;
            next_status = nv_status_byte;
            next_run_boot = (nv_status_byte != STATUS_USER) || strap_boot;
            next_start_addr = next_run_boot ? BOOT_BASE : USER_START;
        end else if (fl_state == FL_DONE) begin
            if (op_q == OP_CLR_STATUS) begin
                next_status = STATUS_USER;
            end else if (op_q == OP_ERASE_CHIP) begin
                next_status = STATUS_FACTORY;
            end
        end
        next_six = fuse_q || ctrl_x2;
        next_ext_fetch = !external_access_select_n;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_valid <= 1'b0;
            run_boot <= 1'b0;
            start_addr <= USER_START;
            fuse_q <= 1'b0;
            status_q <= STATUS_USER;
            six_clk_mode <= 1'b0;
            ext_fetch <= 1'b0;
        end else begin
            config_valid <= next_config_valid;
            run_boot <= next_run_boot;
            start_addr <= next_start_addr;
            fuse_q <= next_fuse;
            status_q <= next_status;
            six_clk_mode <= next_six;
            ext_fetch <= next_ext_fetch;
        end
    end

    // ************************************************************
    // machine cycle divider
    // ************************************************************
    always_comb begin
        div_last = 4'((six_clk_mode ? DIV_SIX : DIV_TWELVE) - 4'h1);
        next_div_cnt = div_cnt;
        next_core_clk_en = 1'b0;
        if (config_valid) begin
            if (div_cnt >= div_last) begin
                next_div_cnt = 4'h0;
                next_core_clk_en = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 4'h0;
            core_clk_en <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            core_clk_en <= next_core_clk_en;
        end
    end

    // ************************************************************
    // flash operation sequencer and writable registers
    // ************************************************************
    assign wr_en = psel && penable && pwrite && pready;
    assign cmd_code = pwdata[2:0];

    always_comb begin
        next_x2 = ctrl_x2;
        next_addr = addr_q;
        next_data = data_q;
        next_fl_state = fl_state;
        next_op = op_q;
        next_wait_cnt = wait_cnt;
        next_flash_op = OP_NONE;
        next_flash_addr = flash_addr;
        next_flash_wdata = flash_wdata;
        if (wr_en) begin
            case (paddr)
                REG_CTRL: next_x2 = pwdata[CTRL_X2_BIT];
                REG_ADDR: next_addr = pwdata[15:0];
                REG_DATA: next_data = pwdata[7:0];
                default: ;
            endcase
        end
        case (fl_state)
            FL_IDLE: begin
                // a command written while busy is dropped
                if (wr_en && paddr == REG_CMD && config_valid && cmd_code != OP_NONE && cmd_code <= OP_PROG_FUSE) begin
                    next_op = bcm_op_type'(cmd_code);
                    next_flash_op = bcm_op_type'(cmd_code);
                    next_fl_state = FL_BUSY;
                    next_flash_addr = addr_q;
                    next_flash_wdata = data_q;
                    next_wait_cnt = WAIT_W'(PROG_CYCLES - 1);
                    case (bcm_op_type'(cmd_code))
                        OP_READ: next_wait_cnt = WAIT_W'(READ_CYCLES - 1);
                        OP_ERASE_BLK: begin
                            next_flash_addr = {addr_q[15:BLOCK_SHIFT], BLOCK_SHIFT'(0)};
                            next_wait_cnt = WAIT_W'(BLK_ERASE_WAIT - 1);
                        end
                        // chip erase restores the status byte to all ones; fuse_q keeps its value until reset
                        OP_ERASE_CHIP: begin
                            next_flash_addr = USER_START;
                            next_wait_cnt = WAIT_W'(CHIP_ERASE_WAIT - 1);
                        end
                        default: ;
                    endcase
                end
            end
            FL_BUSY: begin
                if (wait_cnt == '0) begin
                    next_fl_state = FL_DONE;
                end else begin
                    next_wait_cnt = wait_cnt - 1'b1;
                end
            end
            FL_DONE: begin
                next_fl_state = FL_IDLE;
                if (op_q == OP_READ) begin
                    next_data = flash_rdata;
                end
            end
            default: next_fl_state = FL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_x2 <= CTRL_X2_RST;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
            fl_state <= FL_IDLE;
            op_q <= OP_NONE;
            wait_cnt <= '0;
            flash_op <= OP_NONE;
            flash_addr <= 16'h0000;
            flash_wdata <= 8'h00;
        end else begin
            ctrl_x2 <= next_x2;
            addr_q <= next_addr;
            data_q <= next_data;
            fl_state <= next_fl_state;
            op_q <= next_op;
            wait_cnt <= next_wait_cnt;
            flash_op <= next_flash_op;
            flash_addr <= next_flash_addr;
            flash_wdata <= next_flash_wdata;
        end
    end

    // ************************************************************
    // apb response, one wait-free access phase
    // ************************************************************
    always_comb begin
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                REG_CTRL: next_prdata[CTRL_X2_BIT] = ctrl_x2;
                REG_STATUS: begin
                    next_prdata[ST_BOOT_BIT] = run_boot;
                    next_prdata[ST_SIX_BIT] = six_clk_mode;
                    next_prdata[ST_FUSE_BIT] = fuse_q;
                    next_prdata[ST_BUSY_BIT] = (fl_state != FL_IDLE);
                    next_prdata[ST_LOCK_BIT] = baud_locked;
                    next_prdata[ST_EXT_BIT] = ext_fetch;
                    next_prdata[ST_BYTE_LSB +: 8] = status_q;
                end
                REG_ADDR: next_prdata[15:0] = addr_q;
                REG_DATA: next_prdata[7:0] = data_q;
                REG_CMD: next_prdata[2:0] = op_q;
                REG_BAUD: next_prdata[15:0] = baud_reload;
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // serial programming only in boot loader
    bcm_baud_detect u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .enable(config_valid && run_boot),
        .rxd(rxd),
        .txd(txd),
        .locked(baud_locked),
        .reload(baud_reload)
    );

    // ************************************************************
    // checks
    // ************************************************************
    localparam int PROG_WAIT = PROG_CYCLES;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_user_start;
        $rose(config_valid) && $past(nv_status_byte) == STATUS_USER && !$past(strap_boot)
            |-> !run_boot && start_addr == USER_START;
    endproperty
    a_user_start: assert property (p_user_start) else $error("zero status did not start user code");

    property p_boot_status;
        $rose(config_valid) && $past(nv_status_byte) != STATUS_USER |-> run_boot && start_addr == BOOT_BASE;
    endproperty
    a_boot_status: assert property (p_boot_status) else $error("nonzero status did not start boot");

    property p_strap_boot;
        $rose(config_valid) && $past(strap_boot) |-> run_boot;
    endproperty
    a_strap_boot: assert property (p_strap_boot) else $error("strap pins did not force boot");

    property p_boot_hold;
        config_valid |=> config_valid && $stable(run_boot) && $stable(start_addr) && $stable(fuse_q);
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot choice changed before reset");

    property p_fuse_six;
        config_valid && fuse_q |=> six_clk_mode;
    endproperty
    a_fuse_six: assert property (p_fuse_six) else $error("fuse did not force six-clock");

    property p_x2_mode;
        config_valid && !fuse_q |=> six_clk_mode == $past(ctrl_x2);
    endproperty
    a_x2_mode: assert property (p_x2_mode) else $error("doubler bit did not select mode");

    property p_core_div;
        core_clk_en |=> !core_clk_en [*5];
    endproperty
    a_core_div: assert property (p_core_div) else $error("core enable faster than osc/6");

    property p_ext_fetch;
        config_valid |=> ext_fetch == !$past(external_access_select_n);
    endproperty
    a_ext_fetch: assert property (p_ext_fetch) else $error("external fetch not following pin");

    property p_blk_erase;
        flash_op == OP_ERASE_BLK |-> flash_addr[BLOCK_SHIFT-1:0] == '0 && fl_state == FL_BUSY;
    endproperty
    a_blk_erase: assert property (p_blk_erase) else $error("block erase not block aligned");

    property p_prog_time;
        flash_op == OP_PROG |-> ##[PROG_WAIT:PROG_WAIT] fl_state == FL_DONE;
    endproperty
    a_prog_time: assert property (p_prog_time) else $error("byte program time wrong");

    property p_read_byte;
        fl_state == FL_DONE && op_q == OP_READ |=> data_q == $past(flash_rdata);
    endproperty
    a_read_byte: assert property (p_read_byte) else $error("read byte not captured");

    c_user: cover property ($rose(config_valid) && !run_boot);
    c_boot: cover property ($rose(config_valid) && run_boot && status_q == STATUS_FACTORY);
    c_prog: cover property (flash_op == OP_PROG ##[1:900] fl_state == FL_DONE);
    c_six: cover property (config_valid && six_clk_mode && core_clk_en);

endmodule : bcm_boot_clock_select

`default_nettype wire

/* File: hw/bcm_pkg.sv */
/*
 * shared constants and types for the boot and clock mode select block:
 * flash operation timing, memory map, register offsets and bit fields,
 * operation codes and state encodings.
 * assumes a single 100 MHz clock.
 */
package bcm_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 100;
    localparam int US_PER_S = 1000000;
    localparam int PROG_TIME_US = 8;
    localparam int BLK_ERASE_TIME_S = 3;
    localparam int CHIP_ERASE_TIME_S = 15;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int BLK_ERASE_CYCLES = BLK_ERASE_TIME_S * US_PER_S * CLK_MHZ;
    localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_S * US_PER_S * CLK_MHZ;
    localparam int READ_CYCLES = 1;
    localparam int WAIT_W = 31;
    localparam logic [3:0] DIV_TWELVE = 4'hc;
    localparam logic [3:0] DIV_SIX = 4'h6;

    // ************************************************************
    // memory map and status byte values
    // ************************************************************
    localparam int FLASH_BYTES = 65536;
    localparam int BOOT_BYTES = 1024;
    localparam int BLOCK_SHIFT = 12;
    localparam logic [15:0] USER_START = 16'h0000;
    localparam logic [15:0] BOOT_BASE = 16'(FLASH_BYTES - BOOT_BYTES);
    localparam logic [7:0] STATUS_USER = 8'h00;
    localparam logic [7:0] STATUS_FACTORY = 8'hff;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int APB_AW = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ADDR = 12'h008;
    localparam logic [11:0] REG_DATA = 12'h00c;
    localparam logic [11:0] REG_CMD = 12'h010;
    localparam logic [11:0] REG_BAUD = 12'h014;
    localparam int CTRL_X2_BIT = 0;
    localparam logic CTRL_X2_RST = 1'b0;
    localparam int ST_BOOT_BIT = 0;
    localparam int ST_SIX_BIT = 1;
    localparam int ST_FUSE_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_LOCK_BIT = 4;
    localparam int ST_EXT_BIT = 5;
    localparam int ST_BYTE_LSB = 8;

    // ************************************************************
    // baud measurement
    // ************************************************************
    localparam int BAUD_CNT_W = 20;
    localparam int BAUD_TICK_SHIFT = 4;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_READ = 3'h1,
        OP_PROG = 3'h2,
        OP_ERASE_BLK = 3'h3,
        OP_ERASE_CHIP = 3'h4,
        OP_CLR_STATUS = 3'h5,
        OP_PROG_FUSE = 3'h6
    } bcm_op_type;

    typedef enum logic [1:0] {
        FL_IDLE = 2'b00,
        FL_BUSY = 2'b01,
        FL_DONE = 2'b11
    } bcm_fl_state_type;

    typedef enum logic [1:0] {
        BD_WAIT_IDLE = 2'b00,
        BD_WAIT_START = 2'b01,
        BD_MEASURE = 2'b11,
        BD_LOCKED = 2'b10
    } bcm_bd_state_type;

endpackage : bcm_pkg

/* File: sim/bcm_boot_clock_select_tb_top.sv */
/* bench for the boot and clock mode select block: straps, clock mode, flash ops
   and serial entry. assumes a flash array that always returns 8'h5a. */
`timescale 1ns/1ps
`default_nettype none
module bcm_boot_clock_select_tb_top import bcm_pkg::*; ;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic pready, pslverr, txd, config_valid, run_boot, six_clk_mode, core_clk_en, ext_fetch, rxd, rxd_d, er;
    logic [11:0] paddr = '0, cfg = 12'hffc;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [7:0] fwd;
    logic [15:0] fa, sa;
    bcm_op_type fop;
    int n_errors = 0, total_checks = 0;
    // {status byte, store strobe, access select, latch strobe, fuse, boot expected}
    localparam logic [12:0] BOOTS [5] = '{13'h1ff9, 13'h0018, 13'h000d, 13'h0004, 13'h0799};
    always #5 pclk = ~pclk;
    always @(posedge pclk) rxd_d <= rxd;
    bcm_boot_clock_select #(.BLK_ERASE_WAIT(50), .CHIP_ERASE_WAIT(100)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .program_store_strobe_n(cfg[3]), .external_access_select_n(cfg[2]),
        .address_latch_strobe(cfg[1]), .nv_status_byte(cfg[11:4]), .nv_speed_fuse(cfg[0]),
        .flash_rdata(8'h5a), .flash_op(fop), .flash_addr(fa), .flash_wdata(fwd), .rxd(rxd), .txd(txd),
        .config_valid(config_valid), .run_boot(run_boot), .start_addr(sa), .six_clk_mode(six_clk_mode),
        .core_clk_en(core_clk_en), .ext_fetch(ext_fetch));
    bcm_host_model #(.BIT_CYC(64)) u_host (.pclk(pclk), .go(go), .rxd(rxd));
    // ****************
    // shared tasks
    // ****************
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic rst(input logic [11:0] v);
        @(posedge pclk);
        presetn <= 1'b0;
        cfg <= v;
        // reset hold, two machine cycles after start
        repeat ((total_checks == 0) ? 20 : 24) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask : rst
    // ready, read data and error are taken at the rising edge that ends the access; a hang is left to the watchdog
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic op(input bcm_op_type c, input logic [15:0] ea);
        int n;
        apb(1'b1, REG_CMD, 32'(c));
        @(negedge pclk);
        check("flash_op", 32'(fop), 32'(c));
        if (c != OP_CLR_STATUS) check("flash_addr", 32'(fa), 32'(ea));
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, '0);
            n++;
        end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 400);
    endtask : op
    // ****************
    // scenarios
    // ****************
    task automatic s_boot;
        foreach (BOOTS[i]) begin
            rst(BOOTS[i][12:1]);
            check("config_valid", 32'(config_valid), 32'h1);
            check("run_boot", 32'(run_boot), 32'(BOOTS[i][0]));
            check("start_addr", 32'(sa), BOOTS[i][0] ? 32'(BOOT_BASE) : 32'(USER_START));
            check("ext_fetch", 32'(ext_fetch), 32'(!BOOTS[i][3]));
            @(posedge pclk);
            cfg[11:4] <= ~cfg[11:4];
            repeat (4) @(negedge pclk);
            check("run_boot_held", 32'(run_boot), 32'(BOOTS[i][0]));
        end
    endtask : s_boot
    task automatic s_clock;
        int n;
        for (int k = 0; k < 4; k++) begin
            rst({8'hff, 3'b110, k[1]});
            apb(1'b1, REG_CTRL, 32'(k[0]));
            apb(1'b0, REG_STATUS, '0);
            check("six_status", 32'(rd[ST_SIX_BIT]), 32'(k != 0));
            check("six_clk_mode", 32'(six_clk_mode), 32'(k != 0));
            n = 0;
            do @(negedge pclk); while (core_clk_en !== 1'b1 && ++n < 30);
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (core_clk_en !== 1'b1 && n < 30);
            check("core_period", 32'(n), (k != 0) ? 32'h6 : 32'hc);
        end
    endtask : s_clock
    task automatic s_flash;
        rst(12'hffc);
        apb(1'b1, REG_ADDR, 32'h2345);
        apb(1'b1, REG_DATA, 32'ha7);
        op(OP_PROG, 16'h2345);
        check("flash_wdata", 32'(fwd), 32'ha7);
        op(OP_ERASE_BLK, 16'h2000);
        op(OP_READ, 16'h2345);
        apb(1'b0, REG_DATA, '0);
        check("read_data", rd, 32'h5a);
        op(OP_PROG_FUSE, 16'h2345);
        check("fuse_latched", 32'(rd[ST_FUSE_BIT]), 32'h0);
        op(OP_CLR_STATUS, 16'h0000);
        check("status_cleared", 32'(rd[15:8]), 32'h0);
        op(OP_ERASE_CHIP, 16'h0000);
        check("status_restored", 32'(rd[15:8]), 32'hff);
        check("boot_kept", 32'(run_boot), 32'h1);
        apb(1'b0, 12'h100, '0);
        check("unmapped_err", 32'(er), 32'h1);
        check("unmapped_data", rd, 32'h0);
    endtask : s_flash
    task automatic s_serial;
        rst(12'hffc);
        @(posedge pclk);
        go <= 1'b1;
        repeat (640) begin
            @(negedge pclk);
            check("echo", 32'(txd), 32'(rxd_d));
        end
        apb(1'b0, REG_BAUD, '0);
        check("baud", rd, 32'hfffc);
        apb(1'b0, REG_STATUS, '0);
        check("locked", 32'(rd[ST_LOCK_BIT]), 32'h1);
    endtask : s_serial
    initial begin
        s_boot();
        s_clock();
        s_flash();
        s_serial();
        wrap_up();
    end
    initial begin
        #400000;
        n_errors++;
        wrap_up();
    end
endmodule : bcm_boot_clock_select_tb_top
`default_nettype wire

/* File: sim/bcm_host_model.sv */
/* programming host model: sends one serial character to the block.
   assumes the block's receive line idles high between characters. */
`timescale 1ns/1ps
`default_nettype none
module bcm_host_model #(parameter int BIT_CYC = 64) (
    input wire logic pclk,
    input wire logic go,
    output logic rxd
);
    // ****************
    // character sender
    // ****************
    logic [9:0] frame;
    initial rxd = 1'b1;
    always @(posedge go) begin
        frame = {1'b1, 8'h55, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= frame[i];
            repeat (BIT_CYC) @(posedge pclk);
        end
    end
endmodule : bcm_host_model
`default_nettype wire
